// file: pse_addr_pkg.sv
// Shared constants and types for the serial address and alert front end
package pse_addr_pkg;

  // ==========================================================================
  // Address constants
  localparam logic [2:0] PRIMARY_TOP = 3'h2;     // Upper bits, 010b
  localparam logic [6:0] GLOBAL_ADDR = 7'h30;    // 0110000b
  localparam logic [6:0] ALERT_RESP_ADDR = 7'h0C; // 0001100b
  localparam int MAX_EVENTS = 16;
  localparam logic [3:0] LAST_BIT = 4'h7;        // Count of the eighth bit
  localparam logic [3:0] BYTE_DONE = 4'h8;
  localparam logic [3:0] CNT_RESET = 4'h0;
  localparam logic [7:0] BYTE_RESET = 8'h00;

  // ==========================================================================
  // Types
  typedef enum logic [1:0] {KIND_NONE, KIND_PRIMARY, KIND_GLOBAL, KIND_ALERT}
    addr_kind_t;

  typedef enum logic [2:0] {
    ST_IDLE, ST_ADDR, ST_WR, ST_BYTE_END, ST_ACK_SLV, ST_RD, ST_RD_ACK,
    ST_RD_LOAD
  } bus_state_t;

  // Address match report towards the register logic
  typedef struct packed {
    logic hit;
    addr_kind_t kind;
    logic read;
  } addr_match_t;

  // Received write byte
  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } rx_byte_t;

  // Whole state of the front end
  typedef struct packed {
    logic scl_s1;
    logic scl_s2;
    logic scl_d;
    logic sda_s1;
    logic sda_s2;
    logic sda_d;
    logic [3:0] ad_s1;
    logic [3:0] ad_s2;
    bus_state_t st;
    logic [3:0] cnt;
    logic [7:0] sh;
    logic drive;
    logic read;
    addr_kind_t kind;
    logic addr_hit;
    logic rx_valid;
    logic [7:0] rx_data;
    logic tx_taken;
    logic alert_won;
    logic [MAX_EVENTS-1:0] pending;
    logic alert;
  } front_state_t;

endpackage : pse_addr_pkg

// file: pse_serial_address_alert.sv
// Serial bus slave front end: address match, alert response, split data pin
// ==========================================================================
// What this block does
// - Match primary address 010 plus the four address select pins.
// - Also accept the global address 0110000b on every device.
// - Answer alert response address only while the interrupt is asserted.
// - Enabled port events raise the active-low interrupt output.
// - Interrupt works on a shared line; host reads alert response address.
// - Data in and data out are separate pins; tied they act as one.
// - Device is slave only; host master starts every transfer.
`timescale 1ns/1ps
module pse_serial_address_alert #(
  parameter int NUM_EVENTS = 8
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic scl_pin,
  input wire logic serial_data_input_pin,
  output logic serial_data_output_pin,
  input wire logic [3:0] slave_id_select_pins,
  output logic int_n,
  input wire logic [NUM_EVENTS-1:0] port_events,
  input wire logic [NUM_EVENTS-1:0] event_irq_enable,
  input wire logic [NUM_EVENTS-1:0] event_clear,
  output logic [NUM_EVENTS-1:0] event_pending,
  input wire logic [7:0] tx_data,
  output logic tx_taken,
  output pse_addr_pkg::rx_byte_t rx_byte,
  output pse_addr_pkg::addr_match_t addr_match,
  output logic alert_won
);
  import pse_addr_pkg::*;

  // ==========================================================================
  // Elaboration check
  if (NUM_EVENTS < 1 || NUM_EVENTS > MAX_EVENTS)
  begin : g_bad_events
    $error("NUM_EVENTS must lie between 1 and MAX_EVENTS");
  end

  front_state_t r;
  front_state_t n;
  logic [MAX_EVENTS-1:0] evt;
  logic [MAX_EVENTS-1:0] en;
  logic [MAX_EVENTS-1:0] clr;
  logic scl_rise;
  logic scl_fall;
  logic start_cond;
  logic stop_cond;

  // ==========================================================================
  // Edge and condition detection on synchronised pins
  assign evt = MAX_EVENTS'(port_events & event_irq_enable);
  assign en = MAX_EVENTS'(event_irq_enable);
  assign clr = MAX_EVENTS'(event_clear);
  assign scl_rise = r.scl_s2 & ~r.scl_d;
  assign scl_fall = ~r.scl_s2 & r.scl_d;
  assign start_cond = r.scl_s2 & r.scl_d & ~r.sda_s2 & r.sda_d;
  assign stop_cond = r.scl_s2 & r.scl_d & r.sda_s2 & ~r.sda_d;

  // Classify a received address byte; the alert address needs a live alert
  function automatic addr_kind_t classify(input logic [7:0] b,
                                          input logic [3:0] ad,
                                          input logic alert);
    addr_kind_t k;
    k = KIND_NONE;
    if (b[7:1] == {PRIMARY_TOP, ad})
      k = KIND_PRIMARY;
    else if (b[7:1] == GLOBAL_ADDR)
      k = KIND_GLOBAL;
    else if (b[7:1] == ALERT_RESP_ADDR && alert && b[0])
      k = KIND_ALERT;
    return k;
  endfunction : classify

  // ==========================================================================
  // Next state
  always_comb
  begin
    logic [7:0] sh_in;
    logic [7:0] load;
    logic win;
    sh_in = {r.sh[6:0], r.sda_s2};
    load = (r.kind == KIND_ALERT) ? {PRIMARY_TOP, r.ad_s2, 1'b0} : tx_data;
    win = 1'b0;
    n = r;
    // Two flip-flops before any logic looks at a pin
    n.scl_s1 = scl_pin;
    n.scl_s2 = r.scl_s1;
    n.scl_d = r.scl_s2;
    n.sda_s1 = serial_data_input_pin;
    n.sda_s2 = r.sda_s1;
    n.sda_d = r.sda_s2;
    n.ad_s1 = slave_id_select_pins;
    n.ad_s2 = r.ad_s1;
    n.addr_hit = 1'b0;
    n.rx_valid = 1'b0;
    n.tx_taken = 1'b0;
    n.alert_won = 1'b0;
    case (r.st)
      ST_ADDR:
        if (scl_rise)
        begin
          n.sh = sh_in;
          n.cnt = r.cnt + 4'h1;
          if (r.cnt == LAST_BIT)
          begin
            n.kind = classify(sh_in, r.ad_s2, r.alert);
            n.read = sh_in[0];
            n.addr_hit = (n.kind != KIND_NONE);
            n.st = ST_BYTE_END;
          end
        end
      ST_WR:
        if (scl_rise)
        begin
          n.sh = sh_in;
          n.cnt = r.cnt + 4'h1;
          if (r.cnt == LAST_BIT)
          begin
            n.rx_valid = 1'b1;
            n.rx_data = sh_in;
            n.st = ST_BYTE_END;
          end
        end
      ST_BYTE_END:
        if (scl_fall)
        begin
          // Unmatched address: stay silent, never acknowledge
          n.drive = (r.kind != KIND_NONE);
          n.st = (r.kind != KIND_NONE) ? ST_ACK_SLV : ST_IDLE;
        end
      ST_ACK_SLV, ST_RD_LOAD:
        if (scl_fall)
        begin
          n.cnt = CNT_RESET;
          if (r.read)
          begin
            n.sh = load;
            n.drive = ~load[7];
            n.tx_taken = (r.kind != KIND_ALERT);
            n.st = ST_RD;
          end
          else
          begin
            n.drive = 1'b0;
            n.st = ST_WR;
          end
        end
      ST_RD:
        if (scl_rise)
        begin
          n.cnt = r.cnt + 4'h1;
          // Released a one but the line is low: a lower address won
          if (r.kind == KIND_ALERT && !r.drive && !r.sda_s2)
            n.st = ST_IDLE;
        end
        else if (scl_fall)
        begin
          if (r.cnt == BYTE_DONE)
          begin
            n.drive = 1'b0;
            n.st = ST_RD_ACK;
            win = (r.kind == KIND_ALERT);
          end
          else
          begin
            n.sh = {r.sh[6:0], 1'b0};
            n.drive = ~r.sh[6];
          end
        end
      ST_RD_ACK:
        if (scl_rise)
          n.st = r.sda_s2 ? ST_IDLE : ST_RD_LOAD;
      default:
        n.st = ST_IDLE;
    endcase
    // Start and stop override any transfer in progress
    if (start_cond)
    begin
      n.st = ST_ADDR;
      n.cnt = CNT_RESET;
      n.drive = 1'b0;
      win = 1'b0;
    end
    else if (stop_cond)
    begin
      n.st = ST_IDLE;
      n.drive = 1'b0;
    end
    n.alert_won = win;
    // Enabled events set pending bits; a set in the clear cycle wins
    n.pending = (r.pending & ~clr) | evt;
    if (|evt)
      n.alert = 1'b1;
    else if (win || !(|(n.pending & en)))
      n.alert = 1'b0;
  end

  // ==========================================================================
  // State register
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      r <= '0;
      r.scl_s1 <= 1'b1;
      r.scl_s2 <= 1'b1;
      r.scl_d <= 1'b1;
      r.sda_s1 <= 1'b1;
      r.sda_s2 <= 1'b1;
      r.sda_d <= 1'b1;
      r.st <= ST_IDLE;
      r.kind <= KIND_NONE;
      r.sh <= BYTE_RESET;
      r.cnt <= CNT_RESET;
    end
    else
      r <= n;
  end

  // ==========================================================================
  // Outputs, all from flops; data out pulls low only while driving
  assign serial_data_output_pin = ~r.drive;
  assign int_n = ~r.alert;
  assign event_pending = r.pending[NUM_EVENTS-1:0];
  assign tx_taken = r.tx_taken;
  assign rx_byte = '{valid: r.rx_valid, data: r.rx_data};
  assign addr_match = '{hit: r.addr_hit, kind: r.kind, read: r.read};
  assign alert_won = r.alert_won;

  // ==========================================================================
  // Checks
  primary_match_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    r.addr_hit && r.kind == KIND_PRIMARY |-> r.sh[7:1] == {PRIMARY_TOP, r.ad_s2})
    else $error("primary match on wrong address");
  global_match_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    r.addr_hit && r.kind == KIND_GLOBAL |-> r.sh[7:1] == GLOBAL_ADDR)
    else $error("global match on wrong address");
  alert_addr_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    r.addr_hit && r.kind == KIND_ALERT |-> !int_n && r.sh[7:1] == ALERT_RESP_ADDR)
    else $error("alert address answered without interrupt");
  irq_raise_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    |evt |=> !int_n && ((r.pending & $past(evt)) == $past(evt)))
    else $error("enabled event did not raise interrupt");
  alert_release_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    r.alert_won && !$past(|evt) |-> int_n)
    else $error("interrupt kept after winning alert response");
  data_idle_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    r.st == ST_IDLE |-> serial_data_output_pin)
    else $error("data output pulled low while idle");
  slave_ack_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    r.addr_hit && !start_cond |-> ##[1:64] !serial_data_output_pin)
    else $error("matched address not acknowledged");
  arb_lose_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    r.st == ST_RD && r.kind == KIND_ALERT && scl_rise && !r.drive &&
    !r.sda_s2 && !start_cond && !stop_cond
    |=> r.st == ST_IDLE ##1 !r.alert_won)
    else $error("arbitration loss did not release the bus");
  slave_only_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    !serial_data_output_pin |-> r.st inside {ST_ACK_SLV, ST_WR, ST_RD, ST_RD_ACK})
    else $error("data output driven outside a slave slot");

  primary_write_c: cover property (@(posedge sys_clk) disable iff (sys_rst)
    r.addr_hit && r.kind == KIND_PRIMARY && !r.read ##[1:400] r.rx_valid);
  global_write_c: cover property (@(posedge sys_clk) disable iff (sys_rst)
    r.addr_hit && r.kind == KIND_GLOBAL);
  alert_won_c: cover property (@(posedge sys_clk) disable iff (sys_rst)
    r.alert_won);
  arb_lost_c: cover property (@(posedge sys_clk) disable iff (sys_rst)
    r.st == ST_RD && r.kind == KIND_ALERT && scl_rise && !r.drive && !r.sda_s2);

endmodule : pse_serial_address_alert

// file: host_master.sv
// Host bus master model with an optional rival alert responder
`timescale 1ns/1ps
module host_master (
  input wire logic dev_sda,
  output logic scl,
  output logic sda_line
);
  // ==========================================================================
  // Wired-AND data line with pull-up; a released driver reads as 1
  logic mst_sda = 1'b1;
  logic rival_sda = 1'b1;
  logic [7:0] rival_byte = 8'hFF; // All ones keeps the rival silent
  assign sda_line = mst_sda & rival_sda & dev_sda;
  // Clock line idles high between frames
  initial scl = 1'b1;

  // ==========================================================================
  // Bus phases on a 48 ns clock; only this master starts a transfer
  task automatic start_cond;
    mst_sda = 1'b1;
    #12;
    scl = 1'b1;
    #12;
    mst_sda = 1'b0;
    #12;
    scl = 1'b0;
    #12;
  endtask : start_cond

  task automatic stop_cond;
    mst_sda = 1'b0;
    #12;
    scl = 1'b1;
    #12;
    mst_sda = 1'b1;
    #24;
  endtask : stop_cond

  // Data set mid low phase, line sampled mid high phase
  task automatic bit_xfer(input logic b, output logic got);
    mst_sda = b;
    #12;
    scl = 1'b1;
    #12;
    got = sda_line;
    #12;
    scl = 1'b0;
    #12;
  endtask : bit_xfer

  // Eight bits msb first, then the acknowledge bit; the rival drives too
  task automatic byte_xfer(input logic [7:0] out, input logic ack_out,
      output logic [7:0] got, output logic ack_got);
    for (int i = 7; i >= 0; i--)
    begin
      rival_sda = rival_byte[i];
      bit_xfer(out[i], got[i]);
    end
    rival_sda = 1'b1;
    bit_xfer(ack_out, ack_got);
  endtask : byte_xfer
endmodule : host_master

// file: tb_top.sv
// Testbench: address match, alert response and interrupt scenarios
`timescale 1ns/1ps
module tb_top;
  import pse_addr_pkg::*;
  // ==========================================================================
  // Clock, stimulus and observed pulses
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic scl, sda, dev_sda, int_n, tx_taken, alert_won;
  logic [3:0] sel = 4'hA;
  logic [7:0] ev = 8'h00, ev_en = 8'h04, ev_clr = 8'h00, pend, tx = 8'h3C;
  logic [7:0] rx_last = 8'h00;
  rx_byte_t rx;
  addr_match_t am;
  int miscompares = 0;
  int n_checks = 0;
  int cycles = 0, taken = 0, won = 0, hits = 0;
  always #2.5 sys_clk = ~sys_clk;

  pse_serial_address_alert pse_serial_address_alert_inst (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .scl_pin(scl),
    .serial_data_input_pin(sda), .serial_data_output_pin(dev_sda),
    .slave_id_select_pins(sel), .int_n(int_n), .port_events(ev),
    .event_irq_enable(ev_en), .event_clear(ev_clr), .event_pending(pend),
    .tx_data(tx), .tx_taken(tx_taken), .rx_byte(rx), .addr_match(am),
    .alert_won(alert_won));
  // Data input tied to the wired line, as a single data pin
  host_master host_master_inst (.dev_sda(dev_sda), .scl(scl), .sda_line(sda));

  // Latch one-cycle pulses; the cycle ceiling cuts a hang short
  always @(posedge sys_clk)
  begin
    cycles++;
    taken += (tx_taken === 1'b1);
    won += (alert_won === 1'b1);
    hits += (am.hit === 1'b1);
    if (rx.valid === 1'b1)
      rx_last = rx.data;
    if (cycles == 20000)
    begin
      miscompares++;
      summarize();
    end
  end

  // ==========================================================================
  // Compare, verdict and bus helpers
  task automatic chk(input logic [7:0] exp, input logic [7:0] got);
    n_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("ERROR t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask : chk

  task automatic summarize;
    $display("checks=%0d miscompares=%0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : summarize

  task automatic addr_ph(input logic [6:0] a, input logic rd, output logic k);
    logic [7:0] g;
    host_master_inst.start_cond();
    host_master_inst.byte_xfer({a, rd}, 1'b1, g, k);
  endtask : addr_ph

  // Events and clears are held one cycle, then two cycles settle
  task automatic drive_ev(input logic [7:0] e, input logic [7:0] c);
    @(negedge sys_clk);
    ev = e;
    ev_clr = c;
    @(negedge sys_clk);
    ev = 8'h00;
    ev_clr = 8'h00;
    repeat (2) @(negedge sys_clk);
  endtask : drive_ev

  // ==========================================================================
  // Scenarios
  task automatic s_write(input logic [6:0] a, input addr_kind_t kd);
    logic k;
    logic [7:0] g;
    int h0;
    h0 = hits;
    addr_ph(a, 1'b0, k);
    chk(8'h00, {7'h0, k});
    chk(8'h01, 8'(hits - h0));
    chk(8'h00, {7'h0, am.read});
    chk({6'h0, kd}, {6'h0, am.kind});
    host_master_inst.byte_xfer({a, 1'b1}, 1'b1, g, k);
    chk(8'h00, {7'h0, k});
    host_master_inst.stop_cond();
    chk({a, 1'b1}, rx_last);
  endtask : s_write

  // Foreign primary address and the alert address without interrupt
  task automatic s_refuse;
    logic k;
    int h0;
    h0 = hits;
    addr_ph({PRIMARY_TOP, 4'h5}, 1'b0, k);
    host_master_inst.stop_cond();
    chk(8'h01, {7'h0, k});
    chk(8'h01, {7'h0, int_n});
    addr_ph(ALERT_RESP_ADDR, 1'b1, k);
    host_master_inst.stop_cond();
    chk(8'h01, {7'h0, k});
    chk(8'h00, 8'(hits - h0));
  endtask : s_refuse

  task automatic s_events;
    drive_ev(8'h20, 8'h00);
    chk(8'h01, {7'h0, int_n});
    drive_ev(8'h04, 8'h00);
    chk(8'h00, {7'h0, int_n});
    chk(8'h01, {7'h0, pend[2]});
    drive_ev(8'h00, 8'h04);
    chk(8'h01, {7'h0, int_n});
    // Event and clear in one cycle: the event must win
    drive_ev(8'h04, 8'h04);
    chk(8'h01, {7'h0, pend[2]});
    chk(8'h00, {7'h0, int_n});
    drive_ev(8'h00, 8'h04);
    chk(8'h01, {7'h0, int_n});
  endtask : s_events

  // Alert read; a rival with a lower address makes this device lose
  task automatic s_alert(input logic [7:0] rival);
    logic k;
    logic [7:0] g;
    int w0;
    drive_ev(8'h04, 8'h00);
    w0 = won;
    // Alert address with the write bit is refused even while asserting
    addr_ph(ALERT_RESP_ADDR, 1'b0, k);
    host_master_inst.stop_cond();
    chk(8'h01, {7'h0, k});
    addr_ph(ALERT_RESP_ADDR, 1'b1, k);
    chk(8'h00, {7'h0, k});
    chk({6'h0, KIND_ALERT}, {6'h0, am.kind});
    // Rival joins only for the response byte, not the address byte
    host_master_inst.rival_byte = rival;
    host_master_inst.byte_xfer(8'hFF, 1'b1, g, k);
    host_master_inst.stop_cond();
    host_master_inst.rival_byte = 8'hFF;
    chk(rival & {PRIMARY_TOP, sel, 1'b0}, g);
    chk({7'h0, rival == 8'hFF}, 8'(won - w0));
    chk({7'h0, rival == 8'hFF}, {7'h0, int_n});
    drive_ev(8'h00, 8'hFF);
  endtask : s_alert

  // Two-byte read from a new select code, data sent on the tied pins
  task automatic s_read;
    logic k;
    logic [7:0] g;
    int t0;
    @(negedge sys_clk);
    sel = 4'h3;
    repeat (4) @(negedge sys_clk);
    t0 = taken;
    addr_ph({PRIMARY_TOP, 4'h3}, 1'b1, k);
    chk(8'h00, {7'h0, k});
    chk(8'h01, {7'h0, am.read});
    host_master_inst.byte_xfer(8'hFF, 1'b0, g, k);
    chk(tx, g);
    host_master_inst.byte_xfer(8'hFF, 1'b1, g, k);
    chk(tx, g);
    host_master_inst.stop_cond();
    chk(8'h02, 8'(taken - t0));
  endtask : s_read

  // Reset for two cycles, let synchronisers fill, then run
  initial
  begin
    repeat (2) @(negedge sys_clk);
    sys_rst = 1'b0;
    repeat (4) @(negedge sys_clk);
    s_write({PRIMARY_TOP, 4'hA}, KIND_PRIMARY);
    s_write(GLOBAL_ADDR, KIND_GLOBAL);
    s_refuse();
    s_events();
    s_alert(8'hFF);
    s_alert({PRIMARY_TOP, 4'h0, 1'b0});
    s_read();
    summarize();
  end
endmodule : tb_top
